//--- include/iop_pkg.sv
// Package for the port pin drive and edge interrupt block
package iop_pkg;
    // ==========================================================
    // Bus and register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_DRIVE0 = 8'h00;
    localparam logic [7:0] OFF_DRIVE1 = 8'h04;
    localparam logic [7:0] OFF_DRIVE2 = 8'h08;
    localparam logic [7:0] OFF_OUT = 8'h0c;
    localparam logic [7:0] OFF_SLEW = 8'h10;
    localparam logic [7:0] OFF_INEN = 8'h14;
    localparam logic [7:0] OFF_BIDIR = 8'h18;
    localparam logic [7:0] OFF_CTRL = 8'h1c;
    localparam logic [7:0] OFF_IRQ_LO = 8'h20;
    localparam logic [7:0] OFF_IRQ_HI = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;
    localparam logic [7:0] OFF_PIN_IN = 8'h2c;
    localparam logic [7:0] OFF_REGHI = 8'h30;
    localparam logic [7:0] OFF_OESEL0 = 8'h34;
    localparam logic [7:0] OFF_OESEL1 = 8'h38;
    localparam logic [7:0] OFF_PIN0 = 8'h40;
    localparam logic [7:0] OFF_PIN_LAST = 8'h5c;
    // Control register fields
    localparam int CTRL_LVTTL = 0;
    localparam int CTRL_USB_MODE = 1;
    // Pin form fields
    localparam int PF_OUT = 0;
    localparam int PF_DM_LO = 1;
    localparam int PF_SLEW = 4;
    localparam int PF_INEN = 5;
    localparam int PF_BIDIR = 6;
    localparam int PF_REGHI = 7;
    // Reset values and answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_OESEL = 4'h0;
    localparam logic [7:0] RST_CTRL = 8'h02;

    // ==========================================================
    // Drive modes of the 3-bit drive field
    localparam logic [2:0] DM_ANALOG = 3'h0;
    localparam logic [2:0] DM_HIZ_DIG = 3'h1;
    localparam logic [2:0] DM_RES_UP = 3'h2;
    localparam logic [2:0] DM_RES_DN = 3'h3;
    localparam logic [2:0] DM_OD_LOW = 3'h4;
    localparam logic [2:0] DM_OD_HIGH = 3'h5;
    localparam logic [2:0] DM_STRONG = 3'h6;
    localparam logic [2:0] DM_RES_BOTH = 3'h7;
    // Edge select codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ==========================================================
    // Per-pin drive result
    typedef struct packed {
        logic strong_en;
        logic strong_val;
        logic res_up;
        logic res_dn;
        logic in_en;
        logic slow;
    } iop_drive_t;

    // AXI4-Lite carriers
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } iop_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } iop_axi_rsp_t;
endpackage : iop_pkg

//--- src/iop_pin_drive.sv
// Drive decode of one pin
`timescale 1ns/1ns
module iop_pin_drive (
    input wire logic [2:0] mode,
    input wire logic out_val,
    input wire logic slew_slow,
    input wire logic in_enable,
    input wire logic bidir,
    input wire logic aux_oe,
    input wire logic reg_high,
    input wire logic usb_pin,
    input wire logic usb_mode,
    input wire logic usb_drive,
    input wire logic usb_pull,
    output iop_pkg::iop_drive_t drv
);
    import iop_pkg::*;
    logic [2:0] eff;
    always_comb begin
        eff = (bidir && !aux_oe) ? DM_HIZ_DIG : mode;
        drv = '0;
        drv.in_en = in_enable;
        if (usb_pin) begin
            if (!usb_mode) begin
                drv.in_en = in_enable;
                drv.strong_en = !out_val || usb_drive;
                drv.strong_val = out_val;
                drv.res_up = out_val && !usb_drive && usb_pull;
            end else begin
                drv.in_en = 1'b0;
            end
        end else begin
            case (eff)
                DM_ANALOG: begin
                    drv.in_en = 1'b0;
                end
                DM_HIZ_DIG: begin
                    drv.strong_en = 1'b0;
                end
                DM_RES_UP: begin
                    drv.strong_en = !out_val;
                    drv.res_up = out_val && !reg_high;
                end
                DM_RES_DN: begin
                    drv.strong_en = out_val;
                    drv.strong_val = 1'b1;
                    drv.res_dn = !out_val && !reg_high;
                end
                DM_OD_LOW: begin
                    drv.strong_en = !out_val;
                end
                DM_OD_HIGH: begin
                    drv.strong_en = out_val;
                    drv.strong_val = 1'b1;
                end
                DM_STRONG: begin
                    drv.strong_en = 1'b1;
                    drv.strong_val = out_val;
                end
                DM_RES_BOTH: begin
                    drv.res_up = out_val && !reg_high;
                    drv.res_dn = !out_val && !reg_high;
                end
                default: begin
                    drv.strong_en = 1'b0;
                end
            endcase
            drv.slow = slew_slow && drv.strong_en
                && (eff == DM_OD_LOW || eff == DM_OD_HIGH || eff == DM_STRONG);
        end
    end
endmodule : iop_pin_drive

//--- src/iop_port.sv
// One I/O port: pin drive control, bus registers and edge interrupt unit
// Notes on behaviour
// - USB pins in I/O mode take drive select from drive-enable bits 7 and 6.
// - USB pins in I/O mode enable resistive pull when pull bit set.
// - In USB mode drive-enable and pull-enable settings are ignored.
// - Port-wide drive 0 and drive 1 writes never change the USB pins' drive bits; drive 2 writes do.
// - USB I/O: data 0 strong low; data 1 float, pull-up, or strong high.
// - After reset every pin is analog high-Z, driver and input off.
// - High-Z digital mode disables driver; input buffer follows its enable bit.
// - Resistive pull modes drive one level through a resistor, other strongly.
// - Open-drain modes float on one data value and drive the other.
// - Strong mode drives the data value strongly high and low.
// - Combined resistive mode pulls up for 1 and down for 0.
// - No resistive drive while a regulated pin is at regulated high level.
// - Port form and per-pin form registers update the same settings.
// - Bidirectional pins are high-Z input while their output enable is low.
// - Sixteen auxiliary output enables, each routable to any pins.
// - Per-pin slow slew, effective only in strong and open-drain modes.
// - One edge interrupt unit per port serves all eight pins.
// - Each pin detects rising, falling, both edges, or nothing.
// - Each enabled edge sets its status bit and requests an interrupt.
// - Edge detection keeps working in all sleep modes.
// - Only edges are detected, never levels.
// - Port-wide CMOS/LVTTL threshold; each input buffer disableable in any mode.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module iop_port #(
    parameter int PINS = 8,
    parameter int AUX_W = 16,
    parameter bit USB_PORT = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input iop_pkg::iop_axi_req_t axi_req,
    output iop_pkg::iop_axi_rsp_t axi_rsp,
    input wire logic [15:0] aux_oe,
    input wire logic [7:0] pin_in,
    input wire logic sleep,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_res_up,
    output logic [7:0] pin_res_dn,
    output logic [7:0] pin_in_en,
    output logic [7:0] pin_slow,
    output logic lvttl_sel,
    output logic [7:0] pin_din,
    output logic port_irq
);
    import iop_pkg::*;

    // ==========================================================
    // Parameter check
    if (PINS != 8 || AUX_W != 16) begin : g_bad
        $error("iop_port supports 8 pins and 16 output enables only");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0] dm0;
        logic [7:0] dm1;
        logic [7:0] dm2;
        logic [7:0] out_val;
        logic [7:0] slew;
        logic [7:0] in_en;
        logic [7:0] bidir;
        logic [7:0] reg_high;
        logic [7:0] ctrl;
        logic [7:0] irq_lo;
        logic [7:0] irq_hi;
        logic [7:0] status;
        logic [31:0] oe_sel;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] prev;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
    } iop_state_t;
    localparam iop_state_t ST_RESET = '{ctrl: RST_CTRL, default: '0};

    iop_state_t st;
    iop_state_t next_st;

    logic [7:0] sel_oe;
    logic [7:0] edge_hit;
    logic do_write;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    iop_drive_t drv [8];

    // ==========================================================
    // Per-pin aux routing, edge select and drive decode
    genvar gi;
    for (gi = 0; gi < 8; gi++) begin : g_pin
        logic [1:0] esel;
        logic rose;
        logic fell;
        assign sel_oe[gi] = aux_oe[st.oe_sel[gi*4 +: 4]];
        assign esel = {st.irq_hi[gi], st.irq_lo[gi]};
        assign rose = st.sync2[gi] && !st.prev[gi];
        assign fell = !st.sync2[gi] && st.prev[gi];
        assign edge_hit[gi] = (esel == EDGE_RISE && rose) || (esel == EDGE_FALL && fell)
            || (esel == EDGE_BOTH && (rose || fell));

        iop_pin_drive u_drv (
            .mode({st.dm2[gi], st.dm1[gi], st.dm0[gi]}),
            .out_val(st.out_val[gi]),
            .slew_slow(st.slew[gi]),
            .in_enable(st.in_en[gi]),
            .bidir(st.bidir[gi]),
            .aux_oe(sel_oe[gi]),
            .reg_high(st.reg_high[gi]),
            .usb_pin(USB_PORT && gi >= 6),
            .usb_mode(st.ctrl[CTRL_USB_MODE]),
            .usb_drive(st.dm0[gi]),
            .usb_pull(st.dm1[gi]),
            .drv(drv[gi])
        );
        assign pin_out[gi] = drv[gi].strong_val;
        assign pin_oe[gi] = drv[gi].strong_en;
        assign pin_res_up[gi] = drv[gi].res_up;
        assign pin_res_dn[gi] = drv[gi].res_dn;
        assign pin_in_en[gi] = drv[gi].in_en;
        assign pin_slow[gi] = drv[gi].slow;
        assign pin_din[gi] = drv[gi].in_en & st.sync2[gi];
    end

    assign lvttl_sel = st.ctrl[CTRL_LVTTL];
    assign port_irq = |st.status;

    // ==========================================================
    // Bus outputs
    always_comb begin
        axi_rsp.awready = !st.aw_held && !st.bvalid;
        axi_rsp.wready = !st.w_held && !st.bvalid;
        axi_rsp.bvalid = st.bvalid;
        axi_rsp.bresp = st.bresp;
        axi_rsp.arready = !st.rvalid;
        axi_rsp.rvalid = st.rvalid;
        axi_rsp.rdata = st.rdata;
        axi_rsp.rresp = st.rresp;
    end

    // ==========================================================
    // Byte merge helper
    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nv,
                                          input logic en);
        merge8 = en ? nv : old;
    endfunction : merge8

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] usb_keep;
        logic [7:0] pf;
        logic hit;
        int idx;
        usb_keep = USB_PORT ? 8'hc0 : 8'h00;
        pf = 8'h00;
        hit = 1'b0;
        idx = 0;
        next_st = st;
        // Pin sampling runs with no bus activity, so it works in sleep
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;

        // Write channel capture
        if (axi_req.awvalid && axi_rsp.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = axi_req.wdata;
            next_st.w_strb = axi_req.wstrb;
        end
        do_write = next_st.aw_held && next_st.w_held && !st.bvalid;
        wa = next_st.aw_addr;
        wd = next_st.w_data;
        ws = next_st.w_strb;

        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            case (wa)
                OFF_DRIVE0: next_st.dm0 = (merge8(st.dm0, wd[7:0], ws[0]) & ~usb_keep)
                    | (st.dm0 & usb_keep);
                OFF_DRIVE1: next_st.dm1 = (merge8(st.dm1, wd[7:0], ws[0]) & ~usb_keep)
                    | (st.dm1 & usb_keep);
                OFF_DRIVE2: next_st.dm2 = merge8(st.dm2, wd[7:0], ws[0]);
                OFF_OUT: next_st.out_val = merge8(st.out_val, wd[7:0], ws[0]);
                OFF_SLEW: next_st.slew = merge8(st.slew, wd[7:0], ws[0]);
                OFF_INEN: next_st.in_en = merge8(st.in_en, wd[7:0], ws[0]);
                OFF_BIDIR: next_st.bidir = merge8(st.bidir, wd[7:0], ws[0]);
                OFF_CTRL: next_st.ctrl = merge8(st.ctrl, wd[7:0], ws[0]);
                OFF_IRQ_LO: next_st.irq_lo = merge8(st.irq_lo, wd[7:0], ws[0]);
                OFF_IRQ_HI: next_st.irq_hi = merge8(st.irq_hi, wd[7:0], ws[0]);
                OFF_STATUS: begin
                    if (ws[0]) begin
                        next_st.status = st.status & ~wd[7:0];
                    end
                end
                OFF_REGHI: next_st.reg_high = merge8(st.reg_high, wd[7:0], ws[0]);
                OFF_OESEL0: begin
                    for (int b = 0; b < 4; b++) begin
                        if (ws[b]) begin
                            next_st.oe_sel[b*8 +: 8] = wd[b*8 +: 8];
                        end
                    end
                end
                OFF_PIN_IN: next_st.bresp = RESP_OKAY;
                default: begin
                    hit = wa >= OFF_PIN0 && wa <= OFF_PIN_LAST && wa[1:0] == 2'h0;
                    if (hit && ws[0]) begin
                        idx = int'(wa[4:2]);
                        pf = wd[7:0];
                        next_st.out_val[idx] = pf[PF_OUT];
                        next_st.dm0[idx] = pf[PF_DM_LO];
                        next_st.dm1[idx] = pf[PF_DM_LO+1];
                        next_st.dm2[idx] = pf[PF_DM_LO+2];
                        next_st.slew[idx] = pf[PF_SLEW];
                        next_st.in_en[idx] = pf[PF_INEN];
                        next_st.bidir[idx] = pf[PF_BIDIR];
                        next_st.reg_high[idx] = pf[PF_REGHI];
                    end else if (!hit) begin
                        next_st.bresp = RESP_SLVERR;
                    end
                end
            endcase
        end
        if (st.bvalid && axi_req.bready) begin
            next_st.bvalid = 1'b0;
        end

        // Edge events; a set wins over a same-cycle clear
        next_st.status = next_st.status | edge_hit;

        // Read channel
        if (axi_req.arvalid && axi_rsp.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            case (axi_req.araddr)
                OFF_DRIVE0: next_st.rdata[7:0] = st.dm0;
                OFF_DRIVE1: next_st.rdata[7:0] = st.dm1;
                OFF_DRIVE2: next_st.rdata[7:0] = st.dm2;
                OFF_OUT: next_st.rdata[7:0] = st.out_val;
                OFF_SLEW: next_st.rdata[7:0] = st.slew;
                OFF_INEN: next_st.rdata[7:0] = st.in_en;
                OFF_BIDIR: next_st.rdata[7:0] = st.bidir;
                OFF_CTRL: next_st.rdata[7:0] = st.ctrl;
                OFF_IRQ_LO: next_st.rdata[7:0] = st.irq_lo;
                OFF_IRQ_HI: next_st.rdata[7:0] = st.irq_hi;
                OFF_STATUS: next_st.rdata[7:0] = st.status;
                OFF_PIN_IN: next_st.rdata[7:0] = pin_din;
                OFF_REGHI: next_st.rdata[7:0] = st.reg_high;
                OFF_OESEL0: next_st.rdata = st.oe_sel;
                default: begin
                    if (axi_req.araddr >= OFF_PIN0 && axi_req.araddr <= OFF_PIN_LAST
                        && axi_req.araddr[1:0] == 2'h0) begin
                        idx = int'(axi_req.araddr[4:2]);
                        next_st.rdata[7:0] = {st.reg_high[idx], st.bidir[idx],
                            st.in_en[idx], st.slew[idx], st.dm2[idx], st.dm1[idx],
                            st.dm0[idx], st.out_val[idx]};
                    end else begin
                        next_st.rresp = RESP_SLVERR;
                    end
                end
            endcase
        end else if (st.rvalid && axi_req.rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st <= ST_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end
endmodule : iop_port

//--- test/iop_port_sva.sv
// Checker of the port pin drive and edge interrupt block
`timescale 1ns/1ns
module iop_port_sva #(
    parameter int PINS = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input iop_pkg::iop_axi_req_t axi_req,
    input iop_pkg::iop_axi_rsp_t axi_rsp,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_res_up,
    input wire logic [7:0] pin_res_dn,
    input wire logic [7:0] pin_in_en,
    input wire logic [7:0] pin_slow,
    input wire logic port_irq
);
    import iop_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // Bus handshakes
    sequence wr_take;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready && clk_en;
    endsequence
    sequence rd_take;
        axi_req.arvalid && axi_rsp.arready && !axi_rsp.rvalid && clk_en;
    endsequence
    chk_write_answer: assert property (wr_take |=> axi_rsp.bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (rd_take |=> axi_rsp.rvalid)
        else $error("read response missing");
    chk_bresp_holds: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped");
    chk_rdata_holds: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
    // ==========================================================
    // Pin drive and interrupt
    chk_reset_analog: assert property (@(posedge clk) disable iff (1'b0)
        (!nrst && clk_en) |=> (pin_oe == 8'h00 && pin_in_en == 8'h00 && port_irq == 1'b0))
        else $error("pins not analog after reset");
    chk_slow_driven: assert property ((pin_slow & ~pin_oe) == 8'h00)
        else $error("slow slew without driver");
    chk_pull_drive: assert property (((pin_res_up | pin_res_dn) & pin_oe) == 8'h00
        && (pin_res_up & pin_res_dn) == 8'h00) else $error("pull clashes with drive");
    chk_irq_held: assert property (port_irq && !axi_req.awvalid && !axi_req.wvalid
        |=> port_irq) else $error("request dropped without clear");
    chk_edge_only: assert property ($rose(port_irq) |-> $past(pin_in, 2) != $past(pin_in, 3)
        || $past(pin_in, 3) != $past(pin_in, 4) || $past(pin_in, 1) != $past(pin_in, 2))
        else $error("request without pin edge");
endmodule : iop_port_sva

bind iop_port iop_port_sva #(.PINS(PINS)) u_sva (.clk(clk), .nrst(nrst), .clk_en(clk_en),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .pin_in(pin_in), .pin_oe(pin_oe),
    .pin_res_up(pin_res_up), .pin_res_dn(pin_res_dn), .pin_in_en(pin_in_en),
    .pin_slow(pin_slow), .port_irq(port_irq));

//--- test/iop_pin_env.sv
// Model of the external pin wires
`timescale 1ns/1ns
module iop_pin_env (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_res_up,
    input wire logic [7:0] pin_res_dn,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_oe,
    output logic [7:0] pin_in
);
    logic [7:0] drift = 8'h55;
    // Undriven wires wander every cycle
    always_ff @(posedge clk) begin
        drift <= ~drift;
    end
    always_comb begin
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
            | (~pin_oe & ~ext_oe & (pin_res_up | (~pin_res_dn & drift)));
    end
endmodule : iop_pin_env

//--- test/test_io_port_drive_and_edge_irq.sv
// Testbench of the port pin drive and edge interrupt block
`timescale 1ns/1ns
module test_io_port_drive_and_edge_irq;
    import iop_pkg::*;
    logic clk;
    logic nrst;
    logic sleep;
    logic [15:0] aux_oe;
    logic [7:0] ext_val;
    iop_axi_req_t req;
    iop_axi_rsp_t rsp;
    logic [7:0] pin_in, pin_out, pin_oe, res_up, res_dn, in_en, slow, din;
    logic lvttl;
    logic irq;
    logic hit;
    logic [3:0] e;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    iop_port #(.PINS(8), .AUX_W(16), .USB_PORT(1'b1)) dut (.clk(clk), .nrst(nrst),
        .clk_en(1'b1), .axi_req(req), .axi_rsp(rsp), .aux_oe(aux_oe), .pin_in(pin_in),
        .sleep(sleep), .pin_out(pin_out), .pin_oe(pin_oe), .pin_res_up(res_up),
        .pin_res_dn(res_dn), .pin_in_en(in_en), .pin_slow(slow), .lvttl_sel(lvttl),
        .pin_din(din), .port_irq(irq));
    iop_pin_env env (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_res_up(res_up),
        .pin_res_dn(res_dn), .ext_val(ext_val), .ext_oe(8'h08), .pin_in(pin_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask : check
    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hit, w_hit, aw_done, w_done, v;
        logic [1:0] r;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge clk);
            aw_hit = req.awvalid && rsp.awready;
            w_hit = req.wvalid && rsp.wready;
            @(posedge clk);
            if (aw_hit) begin
                req.awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (w_hit) begin
                req.wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        do begin
            @(negedge clk);
            v = rsp.bvalid;
            r = rsp.bresp;
            @(posedge clk);
        end while (!v);
        req.bready <= 1'b0;
        check("bresp", 32'(er), 32'(r));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic v;
        logic [1:0] r;
        logic [31:0] d;
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(negedge clk);
            v = rsp.arready;
            @(posedge clk);
        end while (!v);
        req.arvalid <= 1'b0;
        do begin
            @(negedge clk);
            v = rsp.rvalid;
            d = rsp.rdata;
            r = rsp.rresp;
            @(posedge clk);
        end while (!v);
        req.rready <= 1'b0;
        check("rresp", 32'(er), 32'(r));
        if (er == RESP_OKAY) check("rdata", exp, d);
    endtask : rd
    function automatic logic [3:0] exp_drv(input logic [2:0] m, input logic d);
        case (m)
            DM_RES_UP: return d ? 4'b0010 : 4'b1000;
            DM_RES_DN: return d ? 4'b1100 : 4'b0001;
            DM_OD_LOW: return d ? 4'b0000 : 4'b1000;
            DM_OD_HIGH: return d ? 4'b1100 : 4'b0000;
            DM_STRONG: return {1'b1, d, 2'b00};
            DM_RES_BOTH: return {2'b00, d, !d};
            default: return 4'b0000;
        endcase
    endfunction : exp_drv

    // ==========================================================
    // Sequence
    initial begin
        req = '0;
        nrst = 1'b0;
        sleep = 1'b0;
        aux_oe = 16'h0000;
        ext_val = 8'h00;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        tick(1);
        check("rst_pins", 32'h0, {pin_oe, in_en, res_up, res_dn});
        check("rst_irq", 32'h0, {din, 7'h0, irq});
        rd(OFF_DRIVE0, 32'h0, RESP_OKAY);
        for (int m = 0; m < 8; m++) begin
            for (int d = 0; d < 2; d++) begin
                wr(OFF_PIN0, {24'h0, 4'b0011, 3'(m), 1'(d)}, RESP_OKAY);
                tick(1);
                e = exp_drv(3'(m), 1'(d));
                check("drive", 32'(e), {pin_oe[0], pin_out[0] & pin_oe[0], res_up[0], res_dn[0]});
                check("slew", 32'(e[3] && m >= 4 && m <= 6), 32'(slow[0]));
                if (m == 1) check("in_en", 32'h1, 32'(in_en[0]));
            end
        end
        wr(OFF_PIN0, 32'h000000a5, RESP_OKAY);
        tick(1);
        check("reghi", 32'h0, {pin_oe[0], res_up[0], res_dn[0]});
        wr(OFF_CTRL, 32'h0, RESP_OKAY);
        wr(8'h58, 32'h25, RESP_OKAY);
        tick(1);
        check("usb_pull", 32'h2, {pin_oe[6], res_up[6], res_dn[6]});
        wr(8'h58, 32'h23, RESP_OKAY);
        wr(OFF_DRIVE0, 32'h00, RESP_OKAY);
        tick(1);
        check("usb_drive", 32'h6, {pin_oe[6], pin_out[6], res_up[6]});
        rd(8'h58, 32'h23, RESP_OKAY);
        wr(OFF_DRIVE1, 32'h02, RESP_OKAY);
        wr(OFF_DRIVE2, 32'h02, RESP_OKAY);
        wr(OFF_OUT, 32'h02, RESP_OKAY);
        tick(1);
        check("port_form", 32'h3, {pin_oe[1], pin_out[1]});
        rd(8'h44, 32'h0d, RESP_OKAY);
        rd(OFF_DRIVE1, 32'h02, RESP_OKAY);
        wr(8'h48, 32'h6d, RESP_OKAY);
        wr(OFF_OESEL0, 32'h00000500, RESP_OKAY);
        tick(1);
        check("bidir_off", 32'h1, {pin_oe[2], in_en[2]});
        @(posedge clk) aux_oe <= 16'h0010;
        tick(1);
        check("aux_other", 32'h1, {pin_oe[2], in_en[2]});
        @(posedge clk) aux_oe <= 16'h0020;
        tick(1);
        check("bidir_on", 32'h3, {pin_oe[2], pin_out[2]});
        wr(OFF_CTRL, 32'h3, RESP_OKAY);
        tick(1);
        check("lvttl", 32'h1, 32'(lvttl));
        check("usb_mode", 32'h0, {pin_oe[6], res_up[6], in_en[6]});
        rd(OFF_CTRL, 32'h3, RESP_OKAY);
        wr(8'h3c, 32'hff, RESP_SLVERR);
        rd(8'h3c, 32'h0, RESP_SLVERR);
        sleep <= 1'b1;
        wr(8'h4c, 32'h22, RESP_OKAY);
        for (int c = 0; c < 4; c++) begin
            wr(OFF_IRQ_LO, {28'h0, 1'(c), 3'h0}, RESP_OKAY);
            wr(OFF_IRQ_HI, {28'h0, 1'(c >> 1), 3'h0}, RESP_OKAY);
            for (int v = 1; v >= 0; v--) begin
                @(posedge clk);
                ext_val[3] <= 1'(v);
                tick(6);
                hit = (v == 1) ? 1'(c) : 1'(c >> 1);
                rd(OFF_STATUS, {28'h0, hit, 3'h0}, RESP_OKAY);
                check("irq", 32'(hit), 32'(irq));
                check("din", 32'(v), 32'(din[3]));
                wr(OFF_STATUS, 32'h08, RESP_OKAY);
                tick(1);
                check("irq_clr", 32'h0, 32'(irq));
            end
        end
        tally_and_finish();
    end
endmodule : test_io_port_drive_and_edge_irq
